/* File: trr_core.sv */
// trr_core: result reporting of two slider engines and the touchkey
// filter units, reached through a byte register port.
// assumes engine results and channel deltas arrive on sys_clk.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - status bit1/bit0 flag multi-touch per engine
// - packets at 0x84-0x86 and 0x87-0x89
// - four-deep result queue per engine
// - byte 0 holds 8-bit position
// - byte 1 holds position minus previous
// - byte 2 holds 7-bit interval, 8ms or 1/4ms
// - top bit shows finger present
// - interrupt on touched to untouched
// - two independent key filter units
// - unit one mode bits 1:0 select top N
// - unit two mode bits 3:2, group two
// - 24-bit group masks at 0x92, 0x96
// - filtered bitmap always valid, 24 channels
// - real-time bitmap of thresholded comparisons
// - presentation bit: live position only
// - touched when change exceeds threshold
module trr_core #(
  parameter int NCH = 24,
  parameter int DW  = 16
) (
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_rd,
  output logic      [7:0]        reg_rdata,
  // engine setup from the ratio engine setup register
  input  wire logic              presentation_select,
  input  wire logic [1:0]        moving_average_filter,
  // engine results, one strobe per computed sample
  input  wire logic [1:0]        res_valid,
  input  wire logic [1:0][7:0]   res_pos,
  input  wire logic [1:0]        res_touch,
  input  wire logic [1:0]        res_multi,
  // per-channel sensing
  input  wire logic [NCH-1:0][DW-1:0] chan_delta,
  input  wire logic [NCH-1:0][DW-1:0] touch_threshold,
  // events
  output logic      [1:0]        slider_event_flag
);
  typedef struct packed {
    logic [7:0]            kf_ctrl;
    logic [1:0][NCH-1:0]   grp;
    logic [NCH-1:0]        rt;
    logic [NCH-1:0]        kf;
    logic [1:0]            multi;
    logic [1:0][7:0]       prev_pos;
    logic [1:0][6:0]       interval;
    logic [1:0][18:0]      tick_cnt;
    logic [1:0]            was_touch;
    logic [1:0][23:0]      live;
    logic [1:0]            evt;
    logic [7:0]            rdata;
  } trr_st_t;
  trr_st_t s_reg, s_next;

  logic [1:0]       q_push;
  logic [1:0]       q_pop;
  logic [1:0][23:0] q_head;
  logic [1:0]       q_ne;
  logic [1:0][23:0] pkt_new;
  logic [1:0][23:0] pkt_view;
  logic [NCH-1:0]   raw_touch;
  logic [1:0][NCH-1:0] sel;

  // touch decision per channel
  always_comb begin
    for (int c = 0; c < NCH; c++) begin
      raw_touch[c] = chan_delta[c] > touch_threshold[c];
    end
  end

  // top-N selector per unit; strict greater-than keeps the lower channel on ties
  always_comb begin
    logic [NCH-1:0] cand;
    logic [NCH-1:0] pick;
    logic [DW-1:0]  best;
    int             bi;
    logic [1:0]     mode;
    cand = '0;
    pick = '0;
    best = '0;
    bi   = 0;
    mode = '0;
    for (int u = 0; u < 2; u++) begin
      mode = s_reg.kf_ctrl[2*u +: 2];
      cand = raw_touch & s_reg.grp[u];
      pick = '0;
      for (int k = 0; k < 3; k++) begin
        best = '0;
        bi   = -1;
        for (int c = 0; c < NCH; c++) begin
          if (cand[c] && !pick[c] && (bi < 0 || chan_delta[c] > best)) begin
            best = chan_delta[c];
            bi   = c;
          end
        end
        if (k < int'(mode) && bi >= 0) begin
          pick[bi] = 1'b1;
        end
      end
      sel[u] = pick;
    end
  end

  // queue pushes and register-read pops
  always_comb begin
    for (int e = 0; e < 2; e++) begin
      q_push[e]  = res_valid[e] && !presentation_select;
      pkt_new[e] = {res_touch[e], s_reg.interval[e],
                    res_pos[e] - s_reg.prev_pos[e], res_pos[e]};
      pkt_view[e] = presentation_select ? s_reg.live[e] : q_head[e];
    end
    // the last byte of a packet advances the queue
    q_pop[0] = reg_rd && (reg_addr == trr_pkg::ADDR_PKT1 + 8'h02);
    q_pop[1] = reg_rd && (reg_addr == trr_pkg::ADDR_PKT2 + 8'h02);
  end

  for (genvar g = 0; g < 2; g++) begin : g_q
    trr_queue #(
      .WIDTH (24),
      .DEPTH (trr_pkg::QUEUE_DEPTH)
    ) u_q (
      .sys_clk   (sys_clk),
      .resetn    (resetn),
      .push      (q_push[g]),
      .push_data (pkt_new[g]),
      .pop       (q_pop[g]),
      .head_data (q_head[g]),
      .not_empty (q_ne[g])
    );
  end

  // next state
  always_comb begin
    logic [NCH-1:0] filt;
    logic [18:0]    period;
    filt   = raw_touch;
    period = '0;
    s_next = s_reg;
    s_next.rt = raw_touch;
    // channels outside an active unit's group pass through unchanged
    for (int u = 0; u < 2; u++) begin
      if (s_reg.kf_ctrl[2*u +: 2] != 2'b00) begin
        filt = (filt & ~s_reg.grp[u]) | sel[u];
      end
    end
    s_next.kf = filt;
    s_next.evt = '0;
    for (int e = 0; e < 2; e++) begin
      period = moving_average_filter[e] ? 19'(trr_pkg::TICK_MAF_CYC)
                                        : 19'(trr_pkg::TICK_RAW_CYC);
      if (res_valid[e]) begin
        s_next.multi[e]     = res_multi[e];
        s_next.prev_pos[e]  = res_pos[e];
        s_next.interval[e]  = '0;
        s_next.tick_cnt[e]  = '0;
        s_next.was_touch[e] = res_touch[e];
        s_next.evt[e]       = s_reg.was_touch[e] && !res_touch[e];
        s_next.live[e]      = {16'h0000, res_pos[e]};
      end else if (s_reg.tick_cnt[e] == period - 19'h00001) begin
        s_next.tick_cnt[e] = '0;
        if (s_reg.interval[e] != 7'h7F) begin
          s_next.interval[e] = s_reg.interval[e] + 7'h01;
        end
      end else begin
        s_next.tick_cnt[e] = s_reg.tick_cnt[e] + 19'h00001;
      end
    end
    // register writes; reserved control bits stay zero
    if (reg_wr) begin
      unique case (reg_addr)
        trr_pkg::ADDR_KF_CTRL: s_next.kf_ctrl = {4'h0, reg_wdata[3:0]};
        8'h92: s_next.grp[0][7:0]   = reg_wdata;
        8'h93: s_next.grp[0][15:8]  = reg_wdata;
        8'h94: s_next.grp[0][23:16] = reg_wdata;
        8'h96: s_next.grp[1][7:0]   = reg_wdata;
        8'h97: s_next.grp[1][15:8]  = reg_wdata;
        8'h98: s_next.grp[1][23:16] = reg_wdata;
        default: ;
      endcase
    end
    // read data registered
    s_next.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        trr_pkg::ADDR_STATUS:  s_next.rdata = {6'h00, s_reg.multi};
        8'h84: s_next.rdata = pkt_view[0][7:0];
        8'h85: s_next.rdata = pkt_view[0][15:8];
        8'h86: s_next.rdata = pkt_view[0][23:16];
        8'h87: s_next.rdata = pkt_view[1][7:0];
        8'h88: s_next.rdata = pkt_view[1][15:8];
        8'h89: s_next.rdata = pkt_view[1][23:16];
        trr_pkg::ADDR_KF_CTRL: s_next.rdata = s_reg.kf_ctrl;
        8'h92: s_next.rdata = s_reg.grp[0][7:0];
        8'h93: s_next.rdata = s_reg.grp[0][15:8];
        8'h94: s_next.rdata = s_reg.grp[0][23:16];
        8'h96: s_next.rdata = s_reg.grp[1][7:0];
        8'h97: s_next.rdata = s_reg.grp[1][15:8];
        8'h98: s_next.rdata = s_reg.grp[1][23:16];
        8'h9A: s_next.rdata = s_reg.kf[7:0];
        8'h9B: s_next.rdata = s_reg.kf[15:8];
        8'h9C: s_next.rdata = s_reg.kf[23:16];
        8'hB4: s_next.rdata = s_reg.rt[7:0];
        8'hB5: s_next.rdata = s_reg.rt[15:8];
        8'hB6: s_next.rdata = s_reg.rt[23:16];
        default: s_next.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata         = s_reg.rdata;
  assign slider_event_flag = s_reg.evt;
endmodule // trr_core
`default_nettype wire

/* File: trr_pkg.sv */
// trr_pkg: register map, field positions and reset values of the touch
// result reporting block.
// assumes a byte-addressed register port driven by the host interface logic.
package trr_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_STATUS   = 8'h83;
  localparam logic [7:0] ADDR_PKT1     = 8'h84;
  localparam logic [7:0] ADDR_PKT2     = 8'h87;
  localparam logic [7:0] ADDR_KF_CTRL  = 8'h90;
  localparam logic [7:0] ADDR_GRP1     = 8'h92;
  localparam logic [7:0] ADDR_GRP2     = 8'h96;
  localparam logic [7:0] ADDR_KF_DATA  = 8'h9A;
  localparam logic [7:0] ADDR_RT_TOUCH = 8'hB4;
  // field positions
  localparam int MT1_BIT      = 0;
  localparam int MT2_BIT      = 1;
  localparam int TOUCH_BIT    = 23;
  localparam int PRESENT_BIT  = 6;
  // reset values
  localparam logic [7:0]  KF_CTRL_RST = 8'h00;
  localparam logic [23:0] MASK_RST    = 24'h000000;
  localparam logic [23:0] PKT_RST     = 24'h000000;
  // result queue depth per engine
  localparam int QUEUE_DEPTH = 4;
  // interval tick periods at 40 MHz: 8 ms and 1/4 ms
  localparam int CLK_HZ        = 40000000;
  localparam int TICK_MAF_US   = 8000;
  localparam int TICK_RAW_US   = 250;
  localparam int TICK_MAF_CYC  = CLK_HZ / 1000000 * TICK_MAF_US;
  localparam int TICK_RAW_CYC  = CLK_HZ / 1000000 * TICK_RAW_US;
endpackage

/* File: trr_queue.sv */
// trr_queue: four-entry result queue of one slider engine.
// assumes push and pop come from the same clock; pop when empty is ignored.
`timescale 1ns/1ps
`default_nettype none
module trr_queue #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             resetn,
  // write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  // read side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] head_data,
  output logic                  not_empty
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
    logic [WIDTH-1:0]            head;
  } trr_q_t;
  trr_q_t q_reg, q_next;
  logic do_pop, do_push;

  // when full the newest result is dropped so unread ones stay in order
  always_comb begin
    q_next  = q_reg;
    do_pop  = pop && (q_reg.cnt != '0);
    do_push = push && ((q_reg.cnt != (AW+1)'(DEPTH)) || do_pop);
    if (do_push) begin
      q_next.mem[q_reg.wr] = push_data;
      q_next.wr = q_reg.wr + 1'b1;
    end
    if (do_pop) begin
      q_next.rd = q_reg.rd + 1'b1;
    end
    q_next.cnt = q_reg.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    // registered head word
    if (q_next.cnt == '0) begin
      q_next.head = '0;
    end else begin
      q_next.head = q_next.mem[q_next.rd];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign head_data = q_reg.head;
  assign not_empty = (q_reg.cnt != '0);
endmodule // trr_queue
`default_nettype wire

/* File: trr_core_sva.sv */
// trr_core_sva: port checks of the touch result reporting core.
// assumes a bind onto trr_core with the same channel parameters.
`timescale 1ns/1ps
`default_nettype none
module trr_core_sva #(
  parameter int NCH = 24,
  parameter int DW  = 16
) (
  // clock, reset and register port
  input wire logic                   sys_clk,
  input wire logic                   resetn,
  input wire logic [7:0]             reg_addr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  // engine, sensing and events
  input wire logic [1:0]             res_valid,
  input wire logic [1:0]             res_touch,
  input wire logic [1:0]             res_multi,
  input wire logic [NCH-1:0][DW-1:0] chan_delta,
  input wire logic [NCH-1:0][DW-1:0] touch_threshold,
  input wire logic [1:0]             slider_event_flag
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  logic ch0_hot;
  // channel 0 compare kept outside the properties
  assign ch0_hot = chan_delta[0] > touch_threshold[0];
  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 8'h00)
    else $error("read data not zero without a read");
  unmapped_read_a: assert property (
    reg_rd && reg_addr == 8'hA0 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  status_rsvd_a: assert property (
    reg_rd && reg_addr == trr_pkg::ADDR_STATUS |=> reg_rdata[7:2] == 6'h00)
    else $error("status reserved bits set");
  ctrl_rsvd_a: assert property (
    reg_rd && reg_addr == trr_pkg::ADDR_KF_CTRL |=> reg_rdata[7:4] == 4'h0)
    else $error("control reserved bits set");
  multi_flag_a: assert property (
    res_valid[0] ##1 !res_valid[0] ##1 (reg_rd && reg_addr == trr_pkg::ADDR_STATUS)
    |=> reg_rdata[0] == $past(res_multi[0], 3))
    else $error("multi flag does not follow sample");
  rt_bit_a: assert property (
    reg_rd && reg_addr == trr_pkg::ADDR_RT_TOUCH |=> reg_rdata[0] == $past(ch0_hot, 2))
    else $error("live bit of channel 0 wrong");
  event_cause_a: assert property (
    slider_event_flag[0] |-> $past(res_valid[0]) && !$past(res_touch[0]))
    else $error("event without untouched sample");
  event_pulse_a: assert property (slider_event_flag[0] |=> !slider_event_flag[0])
    else $error("event longer than one cycle");
  // main scenarios reached
  cover property (slider_event_flag[0]);
  cover property (res_valid == 2'b11);
  cover property (reg_rd && reg_addr == trr_pkg::ADDR_KF_DATA);
endmodule // trr_core_sva
bind trr_core trr_core_sva #(.NCH(NCH), .DW(DW)) trr_core_sva_i (.sys_clk, .resetn,
  .reg_addr, .reg_rd, .reg_rdata, .res_valid, .res_touch, .res_multi, .chan_delta,
  .touch_threshold, .slider_event_flag);
`default_nettype wire

/* File: trr_host.sv */
// trr_host: host side of the byte register port, one access at a time.
// assumes read data shows in the cycle after the read edge.
`timescale 1ns/1ps
`default_nettype none
module trr_host (
  // clock
  input  wire logic       sys_clk,
  // register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // idle port from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  // one write pulse; address and data held through the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // data taken just after the edge that registers it
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
endmodule // trr_host
`default_nettype wire

/* File: trr_tb.sv */
// trr_tb: register level tests of the result reporting core.
// assumes trr_host for port cycles; engine and channel inputs driven here.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                sys_clk = 1'b0;
  logic                resetn = 1'b0;
  logic [7:0]          reg_addr, reg_wdata, reg_rdata;
  logic                reg_wr, reg_rd, presentation_select;
  logic [1:0]          moving_average_filter, res_valid, res_touch, res_multi;
  logic [1:0]          slider_event_flag;
  logic [1:0][7:0]     res_pos;
  logic [23:0][15:0]   chan_delta, touch_threshold;
  int                  errors = 0;
  int                  checks_done = 0;
  int                  cyc = 0;
  int                  ev_cnt = 0;
  logic [7:0]          pk [15] = '{8'h10, 8'h10, 8'h80, 8'h30, 8'h20, 8'h82, 8'h28,
                                   8'hF8, 8'h00, 8'h05, 8'hDD, 8'h80, 8'h00, 8'h00, 8'h00};
  logic [7:0]          kf [4] = '{8'h0F, 8'h02, 8'h06, 8'h07};
  always #12.5 sys_clk = ~sys_clk;
  trr_core trr_core_i (.sys_clk, .resetn, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .presentation_select, .moving_average_filter, .res_valid, .res_pos,
    .res_touch, .res_multi, .chan_delta, .touch_threshold, .slider_event_flag);
  trr_host trr_host_i (.sys_clk, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata);
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    trr_host_i.rd(a, d);
    checks_done++;
    if (d !== e) begin
      errors++;
      $display("BAD reg %h exp %h got %h", a, e, d);
    end
  endtask
  // one engine sample; engine 1 keeps position 0x77 and touch
  task automatic smp(input logic [7:0] p, input logic t, input logic [1:0] v, m);
    @(posedge sys_clk);
    res_valid <= v;
    res_pos[0] <= p;
    res_touch[0] <= t;
    res_multi <= m;
    @(posedge sys_clk);
    res_valid <= 2'b00;
  endtask
  // event count and hang guard, run needs about 21000 cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (slider_event_flag[0] === 1'b1) ev_cnt <= ev_cnt + 1;
    if (cyc == 40000) begin
      errors++;
      close_out();
    end
  end
  initial begin
    presentation_select = 1'b0;
    moving_average_filter = 2'b00;
    res_valid = 2'b00;
    res_pos = {8'h77, 8'h00};
    res_touch = 2'b10;
    res_multi = 2'b00;
    chan_delta = '0;
    touch_threshold = {24{16'h0100}};
    repeat (10) @(posedge sys_clk);
    resetn <= 1'b1;
    for (int a = 8'h83; a <= 8'hB6; a++) chk(8'(a), 8'h00);
    smp(8'h10, 1'b1, 2'b11, 2'b11);
    chk(trr_pkg::ADDR_STATUS, 8'h03);
    // long gap gives an interval of two quarter-ms ticks
    repeat (20500) @(posedge sys_clk);
    smp(8'h30, 1'b1, 2'b01, 2'b00);
    chk(trr_pkg::ADDR_STATUS, 8'h02);
    smp(8'h28, 1'b0, 2'b01, 2'b00);
    smp(8'h05, 1'b1, 2'b01, 2'b00);
    smp(8'h06, 1'b1, 2'b01, 2'b00);
    for (int i = 0; i < 15; i++) chk(8'h84 + 8'(i % 3), pk[i]);
    // engine 1 holds one packet: position 0x77 from zero, touch set
    chk(8'h87, 8'h77);
    chk(8'h88, 8'h77);
    chk(8'h89, 8'h80);
    checks_done++;
    if (ev_cnt != 1) begin errors++; $display("BAD events exp 1 got %0d", ev_cnt); end
    presentation_select <= 1'b1;
    smp(8'h5A, 1'b1, 2'b01, 2'b00);
    chk(8'h84, 8'h5A);
    chk(8'h86, 8'h00);
    trr_host_i.wr(trr_pkg::ADDR_KF_CTRL, 8'hF5);
    chk(trr_pkg::ADDR_KF_CTRL, 8'h05);
    trr_host_i.wr(trr_pkg::ADDR_GRP1, 8'h0F);
    trr_host_i.wr(8'h97, 8'h03);
    chk(8'h97, 8'h03);
    chan_delta[3:0] <= {16'h0150, 16'h0300, 16'h0300, 16'h0200};
    chan_delta[9:8] <= {16'h0500, 16'h0400};
    chan_delta[5] <= 16'h0050;
    chk(8'hB4, 8'h0F);
    chk(8'hB5, 8'h03);
    chk(8'h9A, 8'h02);
    chk(8'h9B, 8'h02);
    for (int m = 0; m < 4; m++) begin
      trr_host_i.wr(trr_pkg::ADDR_KF_CTRL, 8'(m));
      chk(8'h9A, kf[m]);
      chk(8'h9B, 8'h03);
    end
    close_out();
  end
endmodule // tb
`default_nettype wire
